// ### core/ltr_pkg.sv
/*
 Shared constants for the line thermal replica: register map, field positions,
 reset values, operating modes and timing counts.
 Assumes a 50 MHz system clock and a 1 kHz current sample rate.
*/
package ltr_pkg;
	// Operating modes of the trip decision
	typedef enum logic [1:0] {LTR_MODE_OFF, LTR_MODE_PULSED, LTR_MODE_LOCKED} ltr_mode_t;

	// Timing: clock period and sample period in ns, derived counts
	localparam int CLK_PERIOD_NS    = 20;
	localparam int SAMPLE_PERIOD_NS = 1000000;
	localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int STEPS_PER_SEC    = 1000000000 / SAMPLE_PERIOD_NS;

	// Sample stream and arithmetic widths
	localparam int SAMPLE_W = 16;
	localparam int RMS_WIN  = 20;
	localparam int FIFO_DEPTH = 32;
	localparam int HEAT_FRAC  = 32;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_TRIP     = 8'h04;
	localparam logic [7:0] REG_ALARM    = 8'h08;
	localparam logic [7:0] REG_UNLOCK   = 8'h0c;
	localparam logic [7:0] REG_RATED    = 8'h10;
	localparam logic [7:0] REG_BASE     = 8'h14;
	localparam logic [7:0] REG_AMBIENT  = 8'h18;
	localparam logic [7:0] REG_STARTUP  = 8'h1c;
	localparam logic [7:0] REG_IREF     = 8'h20;
	localparam logic [7:0] REG_TCONST   = 8'h24;
	localparam logic [7:0] REG_STATUS   = 8'h28;
	localparam logic [7:0] REG_TEMP     = 8'h2c;
	localparam logic [7:0] REG_LEVEL    = 8'h30;
	localparam logic [7:0] REG_RMS_A    = 8'h34;
	localparam logic [7:0] REG_RMS_B    = 8'h38;
	localparam logic [7:0] REG_RMS_C    = 8'h3c;
	localparam logic [7:0] REG_RMS_MAX  = 8'h40;

	// Control and status field positions
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_BLOCK_BIT = 2;
	localparam int CTRL_HRST_BIT  = 3;
	localparam int STAT_TRIP_BIT  = 0;
	localparam int STAT_ALARM_BIT = 1;
	localparam int STAT_LOCK_BIT  = 2;

	// Reset values
	localparam logic [15:0] RST_TRIP    = 16'h0064;
	localparam logic [15:0] RST_ALARM   = 16'h0050;
	localparam logic [15:0] RST_UNLOCK  = 16'h003c;
	localparam logic [15:0] RST_RATED   = 16'h0064;
	localparam logic [15:0] RST_BASE    = 16'h0019;
	localparam logic [15:0] RST_AMBIENT = 16'h0019;
	localparam logic [7:0]  RST_STARTUP = 8'h00;
	localparam logic [15:0] RST_IREF    = 16'h1000;
	localparam logic [15:0] RST_TCONST  = 16'h000a;
endpackage

// ### core/ltr_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides, parameterised width and depth.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module ltr_fifo #(
	parameter int W     = 48,
	parameter int DEPTH = 32
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         inValid,
	output logic              inReady,
	input  wire logic [W-1:0] inData,
	output logic              outValid,
	input  wire logic         outReady,
	output logic [W-1:0]      outData
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wrPtr;
		logic [AW-1:0]           rdPtr;
		logic [AW:0]             count;
	} ltr_fifo_state_t;

	ltr_fifo_state_t s_q, s_d;
	logic push, pop;

	// Honest flags straight from the occupancy count
	assign inReady  = (s_q.count != (AW+1)'(DEPTH));
	assign outValid = (s_q.count != '0);
	assign outData  = s_q.mem[s_q.rdPtr];
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;

	// Pointers wrap explicitly so DEPTH need not be a power of two
	always_comb
	begin
		s_d = s_q;
		if (push)
		begin
			s_d.mem[s_q.wrPtr] = inData;
			s_d.wrPtr = (s_q.wrPtr == AW'(DEPTH-1)) ? '0 : s_q.wrPtr + 1'b1;
		end
		if (pop)
			s_d.rdPtr = (s_q.rdPtr == AW'(DEPTH-1)) ? '0 : s_q.rdPtr + 1'b1;
		if (push && !pop)
			s_d.count = s_q.count + 1'b1;
		else if (pop && !push)
			s_d.count = s_q.count - 1'b1;
	end

	// Storage is not cleared by reset and still takes a push; pointers and count clear
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			s_q.mem   <= s_d.mem;
			s_q.wrPtr <= '0;
			s_q.rdPtr <= '0;
			s_q.count <= '0;
		end
		else
			s_q <= s_d;
	end
endmodule

// ### core/ltr_core.sv
/*
 Line thermal replica: per-phase true RMS, maximum selection, first-order
 thermal step, temperature compare and trip/alarm/reclose-lock decision.
 Assumes phase samples arrive on a valid/ready stream from same-clock logic
 and software sets thresholds over an Avalon-MM slave with waitrequest.
*/
`timescale 1ns/1ps
module ltr_core #(
	parameter int SAMPLE_CYCLES = ltr_pkg::SAMPLE_CYCLES,
	parameter int WIN           = ltr_pkg::RMS_WIN,
	parameter int DEPTH         = ltr_pkg::FIFO_DEPTH
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        sampleValid,
	output logic             sampleReady,
	input  wire logic [15:0] phaseACurrentSample,
	input  wire logic [15:0] phaseBCurrentSample,
	input  wire logic [15:0] phaseCCurrentSample,
	output logic             tripOut,
	output logic             alarmOut,
	output logic             recloseLockOut,
	output logic [15:0]      temperatureOut
);
	localparam int IW    = $clog2(WIN);
	localparam int SUM_W = 32 + IW + 1;
	localparam int SW    = ltr_pkg::SAMPLE_W;
	localparam int HF    = ltr_pkg::HEAT_FRAC;

	typedef struct packed {
		ltr_pkg::ltr_mode_t          mode;
		logic                        block;
		logic                        heatRst;
		logic [15:0]                 tripThr;
		logic [15:0]                 alarmThr;
		logic [15:0]                 unlockThr;
		logic [15:0]                 rated;
		logic [15:0]                 base;
		logic [15:0]                 ambient;
		logic [7:0]                  startup;
		logic [15:0]                 iref;
		logic [15:0]                 tconst;
		logic                        ack;
		logic [31:0]                 rdata;
		logic [31:0]                 tickCnt;
		logic                        initPend;
		logic [2:0][WIN-1:0][31:0]   sq;
		logic [IW-1:0]               wrIdx;
		logic [2:0][SUM_W-1:0]       sum;
		logic                        st2;
		logic                        st3;
		logic [2:0][15:0]            rms;
		logic [15:0]                 rmsMax;
		logic [47:0]                 heat;
		logic [15:0]                 temp;
		logic [15:0]                 level;
		logic                        aboveTrip;
		logic                        trip;
		logic                        alarm;
		logic                        lock;
	} ltr_state_t;

	ltr_state_t s_q, s_d;

	// Square of one signed sample
	function automatic logic [31:0] sqr(input logic [SW-1:0] x);
		logic signed [31:0] p;
		p = $signed(x) * $signed(x);
		return 32'(p);
	endfunction

	// Bitwise integer square root, restoring method
	function automatic logic [15:0] isqrt(input logic [31:0] v);
		logic [31:0] rem;
		logic [15:0] root;
		logic [31:0] trial;
		rem  = v;
		root = '0;
		for (int b = 15; b >= 0; b--)
		begin
			trial = 32'({root, 16'h0000} >> (15 - b)) | (32'h1 << (2 * b));
			trial = ({16'h0000, root} << (b + 1)) | (32'h1 << (2 * b));
			if (rem >= trial)
			begin
				rem  = rem - trial;
				root = root | (16'h0001 << b);
			end
		end
		return root;
	endfunction

	// Byte-lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction

	// Heat value for a startup percentage of rated overtemperature
	function automatic logic [47:0] startHeat(input logic [7:0] pct);
		logic [47:0] n;
		n = {8'h00, pct, 32'h0};
		return n / 48'd100;
	endfunction

	logic        tick;
	logic        pop;
	logic        fifoValid;
	logic [47:0] fifoData;
	logic [SW-1:0] smp [3];
	logic [2:0][31:0] ms;
	logic [31:0] msMax;
	logic [31:0] irefSq;
	logic [47:0] ratio;
	logic [31:0] ratioSat;
	logic [31:0] tDiv;
	logic signed [48:0] diff;
	logic signed [48:0] stepV;
	logic signed [48:0] heatNew;
	logic [15:0] thetaN;
	logic [63:0] overProd;
	logic [63:0] levelProd;
	logic [15:0] tempNow;
	logic        req;
	logic        coolBelow;
	logic        outsOff;

	// Samples queue until the next millisecond step drains one set
	ltr_fifo #(
		.W     (48),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk      (clk),
		.rst_b    (rst_b),
		.inValid  (sampleValid),
		.inReady  (sampleReady),
		.inData   ({phaseCCurrentSample, phaseBCurrentSample, phaseACurrentSample}),
		.outValid (fifoValid),
		.outReady (tick),
		.outData  (fifoData)
	);

	assign tick = (s_q.tickCnt == 32'(SAMPLE_CYCLES - 1));
	assign pop  = tick & fifoValid; // one step per new sample set
	assign smp[0] = fifoData[15:0];
	assign smp[1] = fifoData[31:16];
	assign smp[2] = fifoData[47:32];

	// Mean squares and maximum selection on squares keep the same order as RMS
	always_comb
	begin
		msMax = '0;
		for (int p = 0; p < 3; p++)
		begin
			ms[p] = 32'(s_q.sum[p] / SUM_W'(WIN));
			if (ms[p] > msMax)
				msMax = ms[p];
		end
	end

	// Thermal step arithmetic; heat is Q16.32 relative to rated overtemperature
	always_comb
	begin
		irefSq   = (s_q.iref == '0) ? 32'h1 : s_q.iref * s_q.iref;
		ratio    = {msMax, 16'h0000} / {16'h0000, irefSq};
		ratioSat = (ratio[47:32] != '0) ? 32'hffffffff : ratio[31:0];
		tDiv     = ((s_q.tconst == '0) ? 32'h1 : {16'h0000, s_q.tconst})
			* 32'(ltr_pkg::STEPS_PER_SEC);
		// Heat moves by (target - heat) * dt/T
		diff     = $signed({1'b0, ratioSat, 16'h0000}) - $signed({1'b0, s_q.heat});
		stepV    = diff / $signed({17'h00000, tDiv});
		heatNew  = $signed({1'b0, s_q.heat}) + stepV;
		thetaN   = (s_q.rated > s_q.base) ? s_q.rated - s_q.base : '0;
		overProd  = s_q.heat * {32'h0, thetaN};
		levelProd = s_q.heat * 64'h64;
		tempNow   = overProd[HF +: 16] + s_q.ambient;
	end

	assign req       = avs_read | avs_write;
	assign coolBelow = (s_q.temp < s_q.unlockThr);
	assign outsOff   = s_q.block || (s_q.mode == ltr_pkg::LTR_MODE_OFF);

	// Next state: bus, sample window, thermal step, decision
	always_comb
	begin
		s_d = s_q;
		// Bus answers one cycle after the request; only reads reload read data
		s_d.ack = req & ~s_q.ack;
		if (avs_read && !s_q.ack)
		begin
			case (avs_address)
				ltr_pkg::REG_CTRL:
					s_d.rdata = {28'h0, s_q.heatRst, s_q.block, s_q.mode};
				ltr_pkg::REG_TRIP:    s_d.rdata = {16'h0, s_q.tripThr};
				ltr_pkg::REG_ALARM:   s_d.rdata = {16'h0, s_q.alarmThr};
				ltr_pkg::REG_UNLOCK:  s_d.rdata = {16'h0, s_q.unlockThr};
				ltr_pkg::REG_RATED:   s_d.rdata = {16'h0, s_q.rated};
				ltr_pkg::REG_BASE:    s_d.rdata = {16'h0, s_q.base};
				ltr_pkg::REG_AMBIENT: s_d.rdata = {16'h0, s_q.ambient};
				ltr_pkg::REG_STARTUP: s_d.rdata = {24'h0, s_q.startup};
				ltr_pkg::REG_IREF:    s_d.rdata = {16'h0, s_q.iref};
				ltr_pkg::REG_TCONST:  s_d.rdata = {16'h0, s_q.tconst};
				ltr_pkg::REG_STATUS:
					s_d.rdata = {29'h0, s_q.lock, s_q.alarm, s_q.trip};
				ltr_pkg::REG_TEMP:    s_d.rdata = {16'h0, s_q.temp};
				ltr_pkg::REG_LEVEL:   s_d.rdata = {16'h0, s_q.level};
				ltr_pkg::REG_RMS_A:   s_d.rdata = {16'h0, s_q.rms[0]};
				ltr_pkg::REG_RMS_B:   s_d.rdata = {16'h0, s_q.rms[1]};
				ltr_pkg::REG_RMS_C:   s_d.rdata = {16'h0, s_q.rms[2]};
				ltr_pkg::REG_RMS_MAX: s_d.rdata = {16'h0, s_q.rmsMax};
				default:              s_d.rdata = 32'h0;
			endcase
		end
		// Writes land on the edge where waitrequest is low
		if (avs_write && s_q.ack)
		begin
			case (avs_address)
				ltr_pkg::REG_CTRL:
				begin
					if (avs_byteenable[0])
					begin
						s_d.mode    = ltr_pkg::ltr_mode_t'(avs_writedata[1:0]);
						s_d.block   = avs_writedata[ltr_pkg::CTRL_BLOCK_BIT];
						s_d.heatRst = avs_writedata[ltr_pkg::CTRL_HRST_BIT];
					end
				end
				ltr_pkg::REG_TRIP:
					s_d.tripThr = 16'(merge({16'h0, s_q.tripThr}, avs_writedata, avs_byteenable));
				ltr_pkg::REG_ALARM:
					s_d.alarmThr = 16'(merge({16'h0, s_q.alarmThr}, avs_writedata, avs_byteenable));
				ltr_pkg::REG_UNLOCK:
					s_d.unlockThr = 16'(merge({16'h0, s_q.unlockThr}, avs_writedata,
						avs_byteenable));
				ltr_pkg::REG_RATED:
					s_d.rated = 16'(merge({16'h0, s_q.rated}, avs_writedata, avs_byteenable));
				ltr_pkg::REG_BASE:
					s_d.base = 16'(merge({16'h0, s_q.base}, avs_writedata, avs_byteenable));
				ltr_pkg::REG_AMBIENT:
					s_d.ambient = 16'(merge({16'h0, s_q.ambient}, avs_writedata, avs_byteenable));
				ltr_pkg::REG_STARTUP:
					s_d.startup = 8'(merge({24'h0, s_q.startup}, avs_writedata, avs_byteenable));
				ltr_pkg::REG_IREF:
					s_d.iref = 16'(merge({16'h0, s_q.iref}, avs_writedata, avs_byteenable));
				ltr_pkg::REG_TCONST:
					s_d.tconst = 16'(merge({16'h0, s_q.tconst}, avs_writedata, avs_byteenable));
				default: ;
			endcase
		end

		// Free-running 1 kHz step timer
		s_d.tickCnt = tick ? 32'h0 : s_q.tickCnt + 32'h1;

		// Stage 1: slide the window of squares for every phase
		s_d.st2 = pop;
		if (pop)
		begin
			for (int p = 0; p < 3; p++)
			begin
				s_d.sq[p][s_q.wrIdx] = sqr(smp[p]);
				s_d.sum[p] = s_q.sum[p] - SUM_W'(s_q.sq[p][s_q.wrIdx])
					+ SUM_W'(sqr(smp[p]));
			end
			s_d.wrIdx = (s_q.wrIdx == IW'(WIN - 1)) ? '0 : s_q.wrIdx + 1'b1;
		end

		// Stage 2: RMS values and the thermal step
		s_d.st3 = s_q.st2;
		if (s_q.st2)
		begin
			for (int p = 0; p < 3; p++)
				s_d.rms[p] = isqrt(ms[p]);
			s_d.rmsMax = isqrt(msMax);
			if (s_q.heatRst || s_q.initPend)
			begin
				s_d.heat     = startHeat(s_q.startup);
				s_d.initPend = 1'b0;
			end
			else
				s_d.heat = heatNew[48] ? '0 : heatNew[47:0]; // state carries history
		end

		// Stage 3: temperature, level and threshold compare
		if (s_q.st3)
		begin
			s_d.temp      = tempNow;
			s_d.level     = levelProd[HF +: 16];
			s_d.aboveTrip = (tempNow > s_q.tripThr);
			s_d.alarm     = (tempNow > s_q.alarmThr);
		end

		// Trip and lock decision follows the compared temperature
		case (s_q.mode)
			ltr_pkg::LTR_MODE_PULSED:
			begin
				s_d.trip = s_q.st3 & (tempNow > s_q.tripThr) & ~s_q.aboveTrip;
				if (s_d.trip)
					s_d.lock = 1'b1;
				else if (coolBelow)
					s_d.lock = 1'b0;
			end
			ltr_pkg::LTR_MODE_LOCKED:
			begin
				if (s_q.st3 && tempNow > s_q.tripThr)
					s_d.trip = 1'b1;
				else if (coolBelow)
					s_d.trip = 1'b0;
				s_d.lock = s_d.trip;
			end
			default:
			begin
				s_d.trip = 1'b0;
				s_d.lock = 1'b0;
			end
		endcase

		// Off mode or block silences every status output
		if (outsOff)
		begin
			s_d.trip  = 1'b0;
			s_d.lock  = 1'b0;
			s_d.alarm = 1'b0;
		end
	end

	// One register stage for the whole state; sync reset to constants
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			s_q           <= '0;
			s_q.mode      <= ltr_pkg::LTR_MODE_PULSED;
			s_q.tripThr   <= ltr_pkg::RST_TRIP;
			s_q.alarmThr  <= ltr_pkg::RST_ALARM;
			s_q.unlockThr <= ltr_pkg::RST_UNLOCK;
			s_q.rated     <= ltr_pkg::RST_RATED;
			s_q.base      <= ltr_pkg::RST_BASE;
			s_q.ambient   <= ltr_pkg::RST_AMBIENT;
			s_q.startup   <= ltr_pkg::RST_STARTUP;
			s_q.iref      <= ltr_pkg::RST_IREF;
			s_q.tconst    <= ltr_pkg::RST_TCONST;
			s_q.initPend  <= 1'b1; // startup value loaded at first step
		end
		else
			s_q <= s_d;
	end

	assign avs_waitrequest = req & ~s_q.ack;
	assign avs_readdata    = s_q.rdata;
	assign tripOut         = s_q.trip;
	assign alarmOut        = s_q.alarm;
	assign recloseLockOut  = s_q.lock;
	assign temperatureOut  = s_q.temp;
endmodule

// ### sim/ltr_core_asserts.sv
/*
 Checker for the thermal replica core: bus handshake, step pacing, outputs.
 Assumes it is bound onto ltr_core and sees only that module's ports.
*/
`timescale 1ns/1ps
module ltr_core_asserts #(
	parameter int SAMPLE_CYCLES = 8,
	parameter int WIN           = 4,
	parameter int DEPTH         = 32
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	input  wire logic        sampleReady,
	input  wire logic        tripOut,
	input  wire logic        alarmOut,
	input  wire logic        recloseLockOut,
	input  wire logic [15:0] temperatureOut
);
	// One clock domain, so clock and reset are given once
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// A fresh request always stalls once, then completes
	property p_wait_first;
		($rose(avs_read) || $rose(avs_write)) |-> avs_waitrequest;
	endproperty
	a_wait_first: assert property (p_wait_first) else $error("new request not stalled");
	property p_wait_once;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_wait_once: assert property (p_wait_once) else $error("request stalled twice");
	property p_wait_idle;
		!(avs_read || avs_write) |-> !avs_waitrequest;
	endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("stall without request");
	// Read data stands between read answers
	property p_read_hold;
		!avs_read |=> $stable(avs_readdata);
	endproperty
	a_read_hold: assert property (p_read_hold) else $error("read data moved while idle");
	// Quiet outputs and an open buffer when reset lets go
	property p_out_release;
		$rose(rst_b) |-> !tripOut && !alarmOut && !recloseLockOut && sampleReady
			&& temperatureOut == 16'h0000;
	endproperty
	a_out_release: assert property (p_out_release) else $error("outputs busy after reset");
	// Temperature holds for at least four clocks after it moves, never on consecutive clocks
	property p_temp_hold;
		$changed(temperatureOut) |=> $stable(temperatureOut)[*4];
	endproperty
	a_temp_hold: assert property (p_temp_hold) else $error("temperature moved mid-step");
	property p_trip_lock;
		tripOut |-> recloseLockOut;
	endproperty
	a_trip_lock: assert property (p_trip_lock) else $error("trip without lock");
	property p_alarm_hold;
		$rose(alarmOut) |=> alarmOut[*4];
	endproperty
	a_alarm_hold: assert property (p_alarm_hold) else $error("alarm glitch");
endmodule

bind ltr_core ltr_core_asserts #(.SAMPLE_CYCLES(SAMPLE_CYCLES), .WIN(WIN), .DEPTH(DEPTH))
	ltr_core_asserts_inst (.clk(clk), .rst_b(rst_b), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.sampleReady(sampleReady), .tripOut(tripOut), .alarmOut(alarmOut),
	.recloseLockOut(recloseLockOut), .temperatureOut(temperatureOut));

// ### sim/ltr_front_model.sv
/*
 Behavioural three-phase sampling front end offering sets on valid/ready.
 Assumes the bench sets amplitudes, pacing gap and enable on the same clock.
*/
`timescale 1ns/1ps
module ltr_front_model (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        enable,
	input  wire logic [7:0]  gap,
	input  wire logic        wave,
	input  wire logic [15:0] ampA,
	input  wire logic [15:0] ampB,
	input  wire logic [15:0] ampC,
	output logic             sampleValid,
	input  wire logic        sampleReady,
	output logic [15:0]      phaseA,
	output logic [15:0]      phaseB,
	output logic [15:0]      phaseC
);
	logic [7:0] idleCnt;
	logic [1:0] idx;
	logic [1:0] nextIdx;
	logic       go;

	// Wave is peak, zero, minus peak, zero: a 250 Hz tone at the sample rate
	function automatic logic [15:0] shape(input logic [15:0] a, input logic [1:0] i);
		if (!wave)
			return a;
		return (i == 2'd0) ? a : ((i == 2'd2) ? -a : 16'h0000);
	endfunction

	// Back to back when gap is zero, else after gap plus one idle cycles
	assign nextIdx = sampleValid ? idx + 2'd1 : idx;
	assign go = enable && (sampleValid ? (gap == 8'h00) : (idleCnt >= gap));

	initial
	begin
		sampleValid = 1'b0;
		{phaseA, phaseB, phaseC} = '0;
	end

	// Holds a set until taken; idle lines toggle so stale data never looks steady
	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			sampleValid <= 1'b0;
			idleCnt <= 8'h00;
			idx <= 2'd0;
			{phaseA, phaseB, phaseC} <= ~{phaseA, phaseB, phaseC};
		end
		else if (!sampleValid || sampleReady)
		begin
			idx <= nextIdx;
			sampleValid <= go;
			idleCnt <= (sampleValid || idleCnt == 8'hff) ? 8'h00 : idleCnt + 8'h01;
			if (go)
				{phaseA, phaseB, phaseC} <= {shape(ampA, nextIdx), shape(ampB, nextIdx),
					shape(ampC, nextIdx)};
			else
				{phaseA, phaseB, phaseC} <= ~{phaseA, phaseB, phaseC};
		end
	end
endmodule

// ### sim/testbench.sv
/*
 Self-checking bench: registers, buffer, RMS, heating, trip modes and block.
 Assumes package, FIFO, core, checker and front-end model are compiled first.
*/
`timescale 1ns/1ps
module testbench;
	localparam int SC = 8;
	logic        clk, rst_b, avs_read, avs_write, avs_waitrequest, sampleValid, sampleReady;
	logic        tripOut, alarmOut, recloseLockOut, wave, feedOn;
	logic [7:0]  avs_address, feedGap;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [15:0] phaseA, phaseB, phaseC, ampA, ampB, ampC, temperatureOut;
	int          failCount, samplesChecked, cold, warm;

	// Free-running 50 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	ltr_core #(.SAMPLE_CYCLES(SC), .WIN(4), .DEPTH(32)) ltr_core_inst (.clk(clk),
		.rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .sampleValid(sampleValid),
		.sampleReady(sampleReady), .phaseACurrentSample(phaseA), .phaseBCurrentSample(phaseB),
		.phaseCCurrentSample(phaseC), .tripOut(tripOut), .alarmOut(alarmOut),
		.recloseLockOut(recloseLockOut), .temperatureOut(temperatureOut));
	ltr_front_model ltr_front_model_inst (.clk(clk), .rst_b(rst_b), .enable(feedOn),
		.gap(feedGap), .wave(wave), .ampA(ampA), .ampB(ampB), .ampC(ampC),
		.sampleValid(sampleValid), .sampleReady(sampleReady), .phaseA(phaseA),
		.phaseB(phaseB), .phaseC(phaseC));

	// Range compare; an unknown never counts as inside
	task automatic cmp(input logic [31:0] got, input logic [31:0] lo, hi, input string what);
		samplesChecked++;
		if ((got >= lo && got <= hi) !== 1'b1)
		begin
			failCount++;
			$display("ERROR at %0t: %s got %0d want %0d..%0d", $time, what, got, lo, hi);
		end
	endtask

	// Request held until waitrequest is sampled low at a rising edge, then released
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0 && n < 50)
		begin
			n++;
			@(posedge clk);
		end
		cmp(n, 0, 49, "bus answer");
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic steps(input int n);
		repeat (n * SC) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic outs(input logic [2:0] e, input string what);
		cmp({29'h0, tripOut, alarmOut, recloseLockOut}, {29'h0, e}, {29'h0, e}, what);
	endtask

	task automatic t_regs;
		logic [7:0]  adr [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
			8'h20, 8'h24, 8'h44};
		logic [31:0] exp [11] = '{32'h1, 32'h64, 32'h50, 32'h3c, 32'h64, 32'h19, 32'h19,
			32'h0, 32'h1000, 32'ha, 32'h0};
		for (int i = 0; i < 11; i++)
		begin
			bus(adr[i], 1'b0, 32'h0);
			cmp(rd, exp[i], exp[i], "reset value");
		end
		bus(8'h44, 1'b1, 32'hffff);
		bus(8'h44, 1'b0, 32'h0);
		cmp(rd, 0, 0, "unmapped read");
	endtask

	// Fill until refused at a slow pace, then stall the feed while it drains
	task automatic t_fifo;
		int n;
		n = 0;
		feedGap <= 8'h03;
		feedOn <= 1'b1;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (sampleReady !== 1'b0 && n < 4000);
		cmp(n, 1, 3999, "buffer full");
		feedOn <= 1'b0;
		steps(36);
		cmp(sampleReady, 1, 1, "buffer drained");
		feedGap <= 8'h00;
		feedOn <= 1'b1;
	endtask

	task automatic t_cold;
		steps(6);
		cmp(temperatureOut, 32'h19, 32'h19, "cold temp");
		bus(ltr_pkg::REG_TEMP, 1'b1, 32'hff);
		bus(ltr_pkg::REG_TEMP, 1'b0, 32'h0);
		cmp(rd, 32'h19, 32'h19, "read-only temp");
		bus(ltr_pkg::REG_LEVEL, 1'b0, 32'h0);
		cmp(rd, 0, 0, "cold level");
		bus(ltr_pkg::REG_AMBIENT, 1'b1, 32'h1e);
		steps(2);
		cmp(temperatureOut, 32'h1e, 32'h1e, "ambient shift");
		bus(ltr_pkg::REG_AMBIENT, 1'b1, 32'h19);
	endtask

	// Largest phase in the middle; then a tone whose RMS is peak over root two
	task automatic t_rms;
		{ampA, ampB, ampC} <= {16'h03e8, 16'h0bb8, 16'h07d0};
		steps(40);
		bus(ltr_pkg::REG_RMS_A, 1'b0, 32'h0);
		cmp(rd, 32'h3e8, 32'h3e8, "rms a");
		bus(ltr_pkg::REG_RMS_C, 1'b0, 32'h0);
		cmp(rd, 32'h7d0, 32'h7d0, "rms c");
		bus(ltr_pkg::REG_RMS_MAX, 1'b0, 32'h0);
		cmp(rd, 32'hbb8, 32'hbb8, "rms max");
		wave <= 1'b1;
		{ampA, ampB, ampC} <= {3{16'h07d0}};
		steps(40);
		bus(ltr_pkg::REG_RMS_B, 1'b0, 32'h0);
		cmp(rd, 32'h586, 32'h586, "rms tone");
		wave <= 1'b0;
		{ampA, ampB, ampC} <= '0;
	endtask

	// Heat held at half the rated rise: 100 degrees span plus 25 ambient
	task automatic t_modes;
		int c;
		bus(ltr_pkg::REG_RATED, 1'b1, 32'h7d);
		bus(ltr_pkg::REG_TCONST, 1'b1, 32'h1);
		bus(ltr_pkg::REG_STARTUP, 1'b1, 32'h32);
		bus(ltr_pkg::REG_CTRL, 1'b1, 32'h9);
		steps(3);
		cmp(temperatureOut, 32'h4a, 32'h4b, "held temp");
		bus(ltr_pkg::REG_LEVEL, 1'b0, 32'h0);
		cmp(rd, 32'h31, 32'h32, "held level");
		bus(ltr_pkg::REG_TRIP, 1'b1, 32'h46);
		c = 0;
		repeat (4 * SC)
		begin
			@(negedge clk);
			c += (tripOut === 1'b1);
		end
		cmp(c, 1, 1, "single pulse");
		outs(3'b001, "lock after pulse");
		bus(ltr_pkg::REG_UNLOCK, 1'b1, 32'h50);
		steps(2);
		outs(3'b000, "lock released");
		bus(ltr_pkg::REG_UNLOCK, 1'b1, 32'h3c);
		bus(ltr_pkg::REG_CTRL, 1'b1, 32'ha);
		steps(2);
		outs(3'b101, "locked trip");
		bus(ltr_pkg::REG_TRIP, 1'b1, 32'h64);
		steps(2);
		outs(3'b101, "locked hysteresis");
		bus(ltr_pkg::REG_UNLOCK, 1'b1, 32'h50);
		steps(2);
		outs(3'b000, "locked release");
		bus(ltr_pkg::REG_UNLOCK, 1'b1, 32'h3c);
		bus(ltr_pkg::REG_CTRL, 1'b1, 32'he);
		bus(ltr_pkg::REG_TRIP, 1'b1, 32'h46);
		bus(ltr_pkg::REG_ALARM, 1'b1, 32'h46);
		steps(2);
		outs(3'b000, "blocked");
		bus(ltr_pkg::REG_CTRL, 1'b1, 32'ha);
		steps(2);
		outs(3'b111, "unblocked");
		bus(ltr_pkg::REG_CTRL, 1'b1, 32'h8);
		steps(2);
		outs(3'b000, "off mode");
		bus(ltr_pkg::REG_TRIP, 1'b1, 32'h64);
		bus(ltr_pkg::REG_ALARM, 1'b1, 32'h50);
	endtask

	// Steps from releasing the held heat to the trip pulse at ratio four
	task automatic time_trip(input logic [31:0] start, output int s);
		int n;
		bus(ltr_pkg::REG_CTRL, 1'b1, 32'h9);
		bus(ltr_pkg::REG_STARTUP, 1'b1, start);
		steps(3);
		n = 0;
		bus(ltr_pkg::REG_CTRL, 1'b1, 32'h1);
		do
		begin
			@(negedge clk);
			n++;
		end
		while (tripOut !== 1'b1 && n < 400 * SC);
		s = n / SC;
	endtask

	task automatic t_heat;
		bus(ltr_pkg::REG_CTRL, 1'b1, 32'h9);
		{ampA, ampB, ampC} <= {3{16'h2000}};
		steps(40);
		time_trip(32'h0, cold);
		cmp(cold, 32'hce, 32'hd8, "cold trip steps");
		time_trip(32'h32, warm);
		cmp(warm, 32'h49, 32'h53, "warm trip steps");
		cmp(warm, 0, cold - 1, "warm before cold");
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", samplesChecked, failCount);
		if (failCount == 0 && samplesChecked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Main sequence after four reset cycles
	initial
	begin
		{rst_b, avs_read, avs_write, wave, feedOn} = '0;
		{avs_address, feedGap, avs_writedata} = '0;
		{ampA, ampB, ampC, failCount, samplesChecked} = '0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		$display("register test finished");
		t_fifo();
		$display("buffer test finished");
		t_cold();
		$display("cold test finished");
		t_rms();
		$display("rms test finished");
		t_modes();
		$display("mode test finished");
		t_heat();
		$display("heating test finished");
		summarize();
	end

	// Cuts a hung run short
	initial
	begin
		#(40000 * 20);
		failCount++;
		$display("ERROR at %0t: watchdog expired", $time);
		summarize();
	end
endmodule
